// ==== linefeed_ctrl.sv ====
/*
 Per-channel linefeed state and feed control: state code register
 with shadow, power-fault auto open, drive and audio controls,
 debounced loop closure, ring trip and ring ground, adaptive output
 impedance and open-circuit voltage tracking with boost.
 Assumes measurements come from same-clock logic with a sample
 strobe; only the power fault pin is asynchronous.
*/
`timescale 1ns/100ps
`include "linefeed_consts.svh"

module linefeed_ctrl
   import linefeed_pkg::*;
(
   input wire logic sys_clk, // System clock, 100 MHz
   input wire logic sys_rst, // Async reset, high
   input wire logic clkEn, // Freezes all state when low
   input wire logic feedWrEn, // Feed state control write
   input wire logic [7:0] feedWrData, // Write data, code in [2:0]
   output logic [7:0] feedCtrlRead, // Code and shadow readback
   input wire logic powerFaultPin, // Excess power, async
   input wire logic extRingerMode, // Relay ringing variant
   input wire logic sampleValid, // Measurement strobe
   input wire logic [15:0] loopVoltage, // Tip-ring voltage
   input wire logic [15:0] loopCurrent, // Loop current
   input wire logic [15:0] ringLeadCurrent, // Ring lead current
   input wire logic [15:0] batteryVoltage, // Battery voltage
   input wire logic [4:0] loopCurrentLimit, // Current limit code
   input wire logic [14:0] openCircuitVoltage, // Target voltage
   input wire logic [14:0] commonModeHeadroom, // Top headroom
   input wire logic [14:0] batteryMarginHeadroom, // Bottom headroom
   input wire logic [14:0] ringingMarginHeadroom, // Ringing headroom
   input wire logic [14:0] boostStepVoltage, // Boost step
   input wire logic [15:0] boostLowThreshold, // Boost low amount
   input wire logic [15:0] boostHighThreshold, // Boost high amount
   input wire logic [15:0] adaptiveThreshold, // Impedance switch level
   input wire logic [15:0] closureThreshold, // Loop closure current
   input wire logic [15:0] ringTripThreshold, // Ring trip current
   input wire logic [15:0] groundThreshold, // Ring ground current
   input wire logic [15:0] closureDebounce, // Closure interval
   input wire logic [15:0] ringTripDebounce, // Trip interval
   input wire logic [15:0] groundDebounce, // Ground interval
   output logic tipDriveEn, // Tip drive on, low floats
   output logic ringDriveEn, // Ring drive on, low floats
   output logic reversePolarity, // Reverse feed
   output logic audioPowerUp, // Audio paths powered
   output logic txPathEn, // Transmit path enabled
   output logic lowPowerStandby, // On-hook standby
   output logic ringWaveEn, // Internal ringing waveform
   output logic ringRelayDrive, // External ringer relay
   output logic lowImpedance, // 320 ohm when high
   output logic [4:0] currentLimitOut, // Clamped limit code
   output logic [15:0] trackedTargetVoltage, // Tracked target
   output logic [15:0] targetVoltage, // Applied target
   output logic boostActive, // Boost in effect
   output logic loopClosed, // Debounced off-hook
   output logic ringTripped, // Debounced ring trip
   output logic ringGround, // Debounced ring ground
   output logic autoOpenEvent // Pulse on forced open
);

   logic faultSync1_reg;
   logic faultSync2_reg;
   feed_code_t feedCode_reg;
   feed_code_t feedShadow_reg;
   logic autoOpen_reg;
   logic tipDrive_reg;
   logic ringDrive_reg;
   logic reverse_reg;
   logic audio_reg;
   logic tx_reg;
   logic standby_reg;
   logic ringWave_reg;
   logic ringRelay_reg;
   logic lowImp_reg;
   logic [4:0] limit_reg;
   logic isActive;
   logic isOht;
   logic isDriving;
   logic [`DET_N-1:0] rawDet;
   logic [`DET_N-1:0] stableDet;
   logic [15:0] debLen [`DET_N];
   logic [14:0] marginSel;

   ////////////////////////////////////////////////////////////////
   // Fault pin crosses in from the line side
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         faultSync1_reg <= 1'b0;
         faultSync2_reg <= 1'b0;
      end else if (clkEn) begin
         faultSync1_reg <= powerFaultPin;
         faultSync2_reg <= faultSync1_reg;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Feed state code; a standing fault beats any software write
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         feedCode_reg <= feed_code_t'(`FEED_CODE_RST);
      end else if (clkEn) begin
         if (faultSync2_reg) begin
            feedCode_reg <= FEED_OPEN;
         end else if (feedWrEn) begin
            feedCode_reg <= feed_code_t'(feedWrData[`FEED_CODE_LSB +: 3]);
         end
      end
   end

   // One pulse each time the fault actually moves the code
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         autoOpen_reg <= 1'b0;
      end else if (clkEn) begin
         autoOpen_reg <= faultSync2_reg && (feedCode_reg != FEED_OPEN);
      end
   end

   // Shadow shows the state actually applied to the line
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         feedShadow_reg <= FEED_OPEN;
      end else if (clkEn) begin
         feedShadow_reg <= feedCode_reg;
      end
   end

   assign feedCtrlRead = {1'b0, feedShadow_reg, 1'b0, feedCode_reg};

   ////////////////////////////////////////////////////////////////
   // State classes, decoded from the code so drives meet the shadow
   assign isActive = (feedCode_reg == FEED_FWD_ACTIVE)
      || (feedCode_reg == FEED_REV_ACTIVE);
   assign isOht = (feedCode_reg == FEED_FWD_OHT)
      || (feedCode_reg == FEED_REV_OHT);
   assign isDriving = (feedCode_reg != FEED_OPEN);

   // Lead drives; relay ringing leaves the leads to the ringer
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tipDrive_reg <= 1'b0;
         ringDrive_reg <= 1'b0;
      end else if (clkEn) begin
         unique case (feedCode_reg)
            FEED_OPEN: begin
               tipDrive_reg <= 1'b0;
               ringDrive_reg <= 1'b0;
            end
            FEED_TIP_OPEN: begin
               tipDrive_reg <= 1'b0;
               ringDrive_reg <= 1'b1;
            end
            FEED_RING_OPEN: begin
               tipDrive_reg <= 1'b1;
               ringDrive_reg <= 1'b0;
            end
            FEED_RINGING: begin
               tipDrive_reg <= !extRingerMode;
               ringDrive_reg <= !extRingerMode;
            end
            default: begin
               tipDrive_reg <= 1'b1;
               ringDrive_reg <= 1'b1;
            end
         endcase
      end
   end

   // Polarity and ringing source
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         reverse_reg <= 1'b0;
         ringWave_reg <= 1'b0;
         ringRelay_reg <= 1'b0;
      end else if (clkEn) begin
         reverse_reg <= (feedCode_reg == FEED_REV_ACTIVE)
            || (feedCode_reg == FEED_REV_OHT);
         ringWave_reg <= (feedCode_reg == FEED_RINGING) && !extRingerMode;
         ringRelay_reg <= (feedCode_reg == FEED_RINGING) && extRingerMode;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Audio and standby follow the debounced hook state; transmit does too, except in OHT where it is always on
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         audio_reg <= 1'b0;
         tx_reg <= 1'b0;
         standby_reg <= 1'b0;
      end else if (clkEn) begin
         audio_reg <= (isActive || isOht) && stableDet[`DET_CLOSE];
         tx_reg <= isOht || (isActive && stableDet[`DET_CLOSE]);
         standby_reg <= isActive && !stableDet[`DET_CLOSE];
      end
   end

   // Impedance drops when the loop voltage falls through the level
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         lowImp_reg <= 1'b0;
      end else if (clkEn) begin
         if (!isDriving) begin
            lowImp_reg <= 1'b0;
         end else if (sampleValid) begin
            lowImp_reg <= (loopVoltage < adaptiveThreshold);
         end
      end
   end

   // Codes above the 45 mA point are clamped, not wrapped
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         limit_reg <= 5'h00;
      end else if (clkEn) begin
         if (loopCurrentLimit > 5'(`LIMIT_MAX_CODE)) begin
            limit_reg <= 5'(`LIMIT_MAX_CODE);
         end else begin
            limit_reg <= loopCurrentLimit;
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // Raw detections, each gated to the states where it means anything
   assign rawDet[`DET_CLOSE] = isDriving && (feedCode_reg != FEED_RINGING)
      && (loopCurrent > closureThreshold);
   assign rawDet[`DET_TRIP] = (feedCode_reg == FEED_RINGING)
      && (loopCurrent > ringTripThreshold);
   assign rawDet[`DET_GND] = (feedCode_reg == FEED_TIP_OPEN)
      && (ringLeadCurrent > groundThreshold);
   assign debLen[`DET_CLOSE] = closureDebounce;
   assign debLen[`DET_TRIP] = ringTripDebounce;
   assign debLen[`DET_GND] = groundDebounce;

   for (genvar i = 0; i < `DET_N; i++) begin : g_deb
      debounce_filter u_deb (
         .sys_clk(sys_clk),
         .sys_rst(sys_rst),
         .clkEn(clkEn),
         .rawLevel(rawDet[i]),
         .holdCycles(debLen[i]),
         .stableLevel(stableDet[i])
      );
   end

   ////////////////////////////////////////////////////////////////
   // Tracking uses the wider headroom while ringing
   assign marginSel = (feedCode_reg == FEED_RINGING) ?
      ringingMarginHeadroom : batteryMarginHeadroom;

   voc_tracker u_track (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .clkEn(clkEn),
      .sampleValid(sampleValid),
      .batteryVoltage(batteryVoltage),
      .loopVoltage(loopVoltage),
      .openCircuitVoltage(openCircuitVoltage),
      .commonModeHeadroom(commonModeHeadroom),
      .marginHeadroom(marginSel),
      .boostStepVoltage(boostStepVoltage),
      .boostLowThreshold(boostLowThreshold),
      .boostHighThreshold(boostHighThreshold),
      .trackedTarget(trackedTargetVoltage),
      .boostedTarget(targetVoltage),
      .boostActive(boostActive)
   );

   ////////////////////////////////////////////////////////////////
   // Output drive
   assign tipDriveEn = tipDrive_reg;
   assign ringDriveEn = ringDrive_reg;
   assign reversePolarity = reverse_reg;
   assign audioPowerUp = audio_reg;
   assign txPathEn = tx_reg;
   assign lowPowerStandby = standby_reg;
   assign ringWaveEn = ringWave_reg;
   assign ringRelayDrive = ringRelay_reg;
   assign lowImpedance = lowImp_reg;
   assign currentLimitOut = limit_reg;
   assign loopClosed = stableDet[`DET_CLOSE];
   assign ringTripped = stableDet[`DET_TRIP];
   assign ringGround = stableDet[`DET_GND];
   assign autoOpenEvent = autoOpen_reg;

   ////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);

   property p_open_hiz;
      feedShadow_reg == FEED_OPEN |-> !tipDriveEn && !ringDriveEn;
   endproperty
   a_open_hiz: assert property (p_open_hiz) else $error("open state drives");

   property p_fault_open;
      clkEn && faultSync2_reg |=> feedCode_reg == FEED_OPEN ##1
         (!$past(clkEn) || feedShadow_reg == FEED_OPEN);
   endproperty
   a_fault_open: assert property (p_fault_open) else $error("fault not open");

   property p_audio_off;
      (feedShadow_reg == FEED_FWD_ACTIVE || feedShadow_reg == FEED_REV_ACTIVE)
         && clkEn && !loopClosed && $stable(loopClosed) |=> !audioPowerUp;
   endproperty
   a_audio_off: assert property (p_audio_off) else $error("audio up on-hook");

   property p_standby;
      clkEn && isActive && !loopClosed |=> lowPowerStandby && !audioPowerUp;
   endproperty
   a_standby: assert property (p_standby) else $error("no standby");

   property p_oht_tx;
      feedShadow_reg == FEED_FWD_OHT || feedShadow_reg == FEED_REV_OHT
         |-> txPathEn;
   endproperty
   a_oht_tx: assert property (p_oht_tx) else $error("tx off in oht");

   property p_tip_open;
      feedShadow_reg == FEED_TIP_OPEN |-> !tipDriveEn && ringDriveEn;
   endproperty
   a_tip_open: assert property (p_tip_open) else $error("tip open wrong");

   property p_ring_open;
      feedShadow_reg == FEED_RING_OPEN |-> tipDriveEn && !ringDriveEn;
   endproperty
   a_ring_open: assert property (p_ring_open) else $error("ring open wrong");

   property p_ringing;
      feedShadow_reg == FEED_RINGING |-> ringWaveEn ^ ringRelayDrive;
   endproperty
   a_ringing: assert property (p_ringing) else $error("no ringing source");

   property p_loop_current_limit;
      currentLimitOut <= 5'(`LIMIT_MAX_CODE);
   endproperty
   a_loop_current_limit: assert property (p_loop_current_limit) else $error("limit out of span");

   property p_wr_code;
      clkEn && feedWrEn && !faultSync2_reg |=>
         feedCode_reg == feed_code_t'($past(feedWrData[2:0]));
   endproperty
   a_wr_code: assert property (p_wr_code) else $error("write lost");

   c_ringing: cover property (feedShadow_reg == FEED_RINGING ##1 ringTripped);
   c_auto_open: cover property (autoOpenEvent);
   c_boost: cover property ($rose(boostActive) ##[1:200] $fell(boostActive));
   c_ground: cover property (feedShadow_reg == FEED_TIP_OPEN && ringGround);

endmodule // linefeed_ctrl

// ==== linefeed_consts.svh ====
/*
 Constants for the linefeed state and feed control block: field
 positions, reset values and limits. Assumes inclusion by bare name.
*/
`ifndef LINEFEED_CONSTS_SVH
`define LINEFEED_CONSTS_SVH

// Feed state control layout: code in [2:0], shadow in [6:4]
`define FEED_CODE_LSB 0
`define FEED_SHADOW_LSB 4
`define FEED_CTRL_W 8
`define FEED_CODE_RST 3'h0

// Current limit span and step, in microamperes
`define LIMIT_MIN_UA 18000
`define LIMIT_MAX_UA 45000
`define LIMIT_STEP_UA 875
`define LIMIT_MAX_CODE ((`LIMIT_MAX_UA - `LIMIT_MIN_UA) / `LIMIT_STEP_UA)
`define LIMIT_W 5

// Voltage word width and reset values
`define VOLT_W 16
`define VOLT_RST 16'h0000
`define DEB_RST 16'h0000

// Detector indices
`define DET_CLOSE 0
`define DET_TRIP 1
`define DET_GND 2
`define DET_N 3

`endif

// ==== linefeed_pkg.sv ====
/*
 Types for the linefeed block: feed state codes and boost states.
 Assumes the constants header is compiled alongside.
*/
package linefeed_pkg;

   // Documented feed state codes
   typedef enum logic [2:0] {
      FEED_OPEN = 3'h0,
      FEED_FWD_ACTIVE = 3'h1,
      FEED_FWD_OHT = 3'h2,
      FEED_TIP_OPEN = 3'h3,
      FEED_RINGING = 3'h4,
      FEED_REV_ACTIVE = 3'h5,
      FEED_REV_OHT = 3'h6,
      FEED_RING_OPEN = 3'h7
   } feed_code_t;

   // Boost scheme states, one-hot
   typedef enum logic [1:0] {
      BOOST_OFF = 2'b01,
      BOOST_ON = 2'b10
   } boost_state_t;

endpackage

// ==== debounce_filter.sv ====
/*
 Level debouncer: the output follows the raw level only after it
 has differed for more than holdCycles enabled clocks.
 Assumes rawLevel is on sys_clk.
*/
`timescale 1ns/100ps
`include "linefeed_consts.svh"

module debounce_filter (
   input wire logic sys_clk, // System clock
   input wire logic sys_rst, // Async reset, high
   input wire logic clkEn, // Freezes state when low
   input wire logic rawLevel, // Undebounced detection
   input wire logic [15:0] holdCycles, // Debounce interval
   output logic stableLevel // Debounced detection
);

   logic [15:0] cnt_reg;
   logic stable_reg;

   ////////////////////////////////////////////////////////////////
   // Count disagreement, flip once it outlasts the interval
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_reg <= `DEB_RST;
         stable_reg <= 1'b0;
      end else if (clkEn) begin
         if (rawLevel == stable_reg) begin
            cnt_reg <= `DEB_RST; // Any agreement restarts the wait
         end else if (cnt_reg >= holdCycles) begin
            stable_reg <= rawLevel;
            cnt_reg <= `DEB_RST;
         end else begin
            cnt_reg <= cnt_reg + 16'h0001;
         end
      end
   end

   assign stableLevel = stable_reg;

   property p_deb_hold;
      @(posedge sys_clk) disable iff (sys_rst)
      clkEn && (rawLevel != stable_reg) && (cnt_reg < holdCycles) |=> $stable(stable_reg);
   endproperty
   a_deb_hold: assert property (p_deb_hold) else $error("debounce flipped early");

endmodule // debounce_filter

// ==== voc_tracker.sv ====
/*
 Open-circuit voltage tracking against battery and the boost scheme
 with low and high thresholds. Assumes samples arrive on sys_clk
 with a one-cycle sampleValid strobe.
*/
`timescale 1ns/100ps
`include "linefeed_consts.svh"

module voc_tracker
   import linefeed_pkg::*;
(
   input wire logic sys_clk, // System clock
   input wire logic sys_rst, // Async reset, high
   input wire logic clkEn, // Freezes state when low
   input wire logic sampleValid, // New measurement
   input wire logic [15:0] batteryVoltage, // Battery magnitude
   input wire logic [15:0] loopVoltage, // Tip-ring magnitude
   input wire logic [14:0] openCircuitVoltage, // Programmed target
   input wire logic [14:0] commonModeHeadroom, // Top headroom
   input wire logic [14:0] marginHeadroom, // Battery-side headroom
   input wire logic [14:0] boostStepVoltage, // Boost amount
   input wire logic [15:0] boostLowThreshold, // Below-track amount
   input wire logic [15:0] boostHighThreshold, // Above-track amount
   output logic [15:0] trackedTarget, // Tracked target
   output logic [15:0] boostedTarget, // Applied target
   output logic boostActive // Boost in effect
);

   logic [16:0] batWide;
   logic [16:0] headSum;
   logic [16:0] loopWide;
   logic [16:0] trackWide;
   logic [16:0] boostSum;
   logic [15:0] track_reg;
   logic [15:0] track_next;
   logic [15:0] target_reg;
   boost_state_t boost_reg;

   ////////////////////////////////////////////////////////////////
   // Battery tracking, 17 bits so the sums cannot wrap
   assign batWide = {1'b0, batteryVoltage};
   assign headSum = {2'b00, openCircuitVoltage} + {2'b00, commonModeHeadroom}
      + {2'b00, marginHeadroom};
   assign loopWide = {1'b0, loopVoltage};
   assign trackWide = {1'b0, track_reg};
   always_comb begin
      if (batWide > headSum) begin
         track_next = {1'b0, openCircuitVoltage};
      end else if (batWide > headSum - {2'b00, openCircuitVoltage}) begin
         track_next = 16'(batWide - {2'b00, commonModeHeadroom}
            - {2'b00, marginHeadroom});
      end else begin
         track_next = `VOLT_RST; // No room left at all
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         track_reg <= `VOLT_RST;
      end else if (clkEn && sampleValid) begin
         track_reg <= track_next;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Boost state: collapse below low level, release above high level
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         boost_reg <= BOOST_OFF;
      end else if (clkEn && sampleValid) begin
         unique case (boost_reg)
            BOOST_OFF: begin
               if (loopWide + {1'b0, boostLowThreshold} < trackWide) begin
                  boost_reg <= BOOST_ON;
               end
            end
            BOOST_ON: begin
               if (loopWide > trackWide + {1'b0, boostHighThreshold}) begin
                  boost_reg <= BOOST_OFF;
               end
            end
            default: begin
               boost_reg <= BOOST_OFF;
            end
         endcase
      end
   end

   // Applied target saturates rather than wraps
   assign boostSum = trackWide + {2'b00, boostStepVoltage};
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         target_reg <= `VOLT_RST;
      end else if (clkEn) begin
         if (boost_reg == BOOST_ON) begin
            target_reg <= boostSum[16] ? 16'hFFFF : boostSum[15:0];
         end else begin
            target_reg <= track_reg;
         end
      end
   end

   assign trackedTarget = track_reg;
   assign boostedTarget = target_reg;
   assign boostActive = (boost_reg == BOOST_ON);

   property p_track_equal;
      @(posedge sys_clk) disable iff (sys_rst)
      clkEn && sampleValid && (batWide > headSum)
         |=> track_reg == {1'b0, $past(openCircuitVoltage)};
   endproperty
   a_track_equal: assert property (p_track_equal) else $error("track off setting");

   property p_boost_rest;
      @(posedge sys_clk) disable iff (sys_rst)
      clkEn && (boost_reg == BOOST_OFF) |=> target_reg == $past(track_reg);
   endproperty
   a_boost_rest: assert property (p_boost_rest) else $error("target not tracked");

endmodule // voc_tracker

// ==== loop_model.sv ====
/* Subscriber loop model: strobes measurements, draws current off-hook.
 Assumes the bench drives offHook and watches the lead drives. */
`timescale 1ns/100ps
module loop_model (
   input wire logic sys_clk, // Clock
   input wire logic offHook, // Handset state
   input wire logic tipDriveEn, // Tip fed
   input wire logic ringDriveEn, // Ring fed
   input wire logic ringGnd, // Ring lead grounded
   output logic sampleValid = 1'b0, // Strobe
   output logic [15:0] loopVoltage = 16'h4000, // Tip-ring
   output logic [15:0] loopCurrent = 16'h0000, // Loop current
   output logic [15:0] ringLeadCurrent = 16'h0000 // Ring lead
);
   logic [1:0] div = 2'h0;
   ////////////////////////////////////////
   // Strobe every fourth cycle; no current over an unfed loop
   always @(negedge sys_clk) begin
      div <= div + 2'h1;
      sampleValid <= (div == 2'h0);
      loopCurrent <= (offHook & tipDriveEn & ringDriveEn) ? 16'h2000 : 16'h0000;
      loopVoltage <= offHook ? 16'h0800 : 16'h4000; // Collapse off-hook
      ringLeadCurrent <= (ringGnd & ringDriveEn) ? 16'h2000 : 16'h0000; // Fed ring only
   end
endmodule // loop_model

// ==== linefeed_ctrl_bench.sv ====
/* Bench for linefeed_ctrl: feed codes, hook, boost, fault, limit.
 Assumes loop_model on the far side. */
`timescale 1ns/100ps
module linefeed_ctrl_bench;
   logic sys_clk = 1'b0, sys_rst = 1'b1, feedWrEn = 1'b0, pf = 1'b0, offHook = 1'b0;
   logic ext = 1'b0, sv, seenEv = 1'b0, gndLead = 1'b0, trp, gnd;
   logic [7:0] wd = 8'h00, rd;
   logic [4:0] limSet = 5'h05, lim;
   logic [14:0] ocv = 15'h1000, hr = 15'h0100; // Even word codes
   logic [15:0] th = 16'h0400, tc = 16'h1000, deb = 16'h0002, bat = 16'h8000;
   logic [15:0] lv, lc, rc, trk, tgt;
   logic tip, ring, rev, aud, tx, lps, rw, rly, lz, bst, cl, ev;
   int miscompares = 0, check_count = 0, cyc = 0;
   linefeed_ctrl u_linefeed_ctrl (.sys_clk(sys_clk), .sys_rst(sys_rst), .clkEn(1'b1),
      .feedWrEn(feedWrEn), .feedWrData(wd), .feedCtrlRead(rd), .powerFaultPin(pf),
      .extRingerMode(ext), .sampleValid(sv), .loopVoltage(lv), .loopCurrent(lc),
      .ringLeadCurrent(rc), .batteryVoltage(bat), .loopCurrentLimit(limSet),
      .openCircuitVoltage(ocv), .commonModeHeadroom(hr), .batteryMarginHeadroom(hr),
      .ringingMarginHeadroom(hr), .boostStepVoltage(15'h0200), .boostLowThreshold(th),
      .boostHighThreshold(th), .adaptiveThreshold(tc), .closureThreshold(tc),
      .ringTripThreshold(tc), .groundThreshold(tc), .closureDebounce(deb),
      .ringTripDebounce(deb), .groundDebounce(deb), .tipDriveEn(tip), .ringDriveEn(ring),
      .reversePolarity(rev), .audioPowerUp(aud), .txPathEn(tx), .lowPowerStandby(lps),
      .ringWaveEn(rw), .ringRelayDrive(rly), .lowImpedance(lz), .currentLimitOut(lim),
      .trackedTargetVoltage(trk), .targetVoltage(tgt), .boostActive(bst),
      .loopClosed(cl), .ringTripped(trp), .ringGround(gnd), .autoOpenEvent(ev));
   loop_model u_loop_model (.sys_clk(sys_clk), .offHook(offHook), .tipDriveEn(tip),
      .ringDriveEn(ring), .ringGnd(gndLead), .sampleValid(sv), .loopVoltage(lv), .loopCurrent(lc),
      .ringLeadCurrent(rc));
   ////////////////////////////////////////
   // Clock, hang guard and fault pulse catcher
   initial forever #5 sys_clk = ~sys_clk;
   always @(negedge sys_clk) begin
      cyc++;
      if (ev === 1'b1) seenEv = 1'b1; // Pulse lasts one cycle only
      if (cyc == 4000) begin
         miscompares++;
         close_out();
      end
   end
   task automatic chk(string n, logic [15:0] e, logic [15:0] s);
      check_count++;
      if (s !== e) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic close_out();
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Write strobe, then let code and shadow settle
   task automatic wr(logic [7:0] c);
      feedWrEn = 1'b1;
      wd = c;
      @(negedge sys_clk) feedWrEn = 1'b0;
      repeat (3) @(negedge sys_clk);
   endtask
   ////////////////////////////////////////
   task automatic t_states();
      logic [2:0] c;
      chk("reset", 16'h0000, {rd, tip, ring});
      for (int i = 0; i < 8; i++) begin
         c = i[2:0];
         wr({5'h1F, c});
         chk("read", {1'b0, c, 1'b0, c}, rd);
         chk("ctl", {c != 0 && c != 3, c != 0 && c != 7, c == 5 || c == 6, c == 1 || c == 5,
            c == 2 || c == 6, c == 4}, {tip, ring, rev, lps, tx, rw});
      end
      ext = 1'b1;
      wr(8'h04);
      chk("relay", 3'b100, {rly, tip, ring});
      ext = 1'b0;
   endtask
   // Off-hook collapse boosts, on-hook return withdraws it
   task automatic t_hook();
      wr(8'h01);
      offHook = 1'b1;
      for (int i = 0; i < 60 && cl !== 1'b1; i++) @(negedge sys_clk);
      repeat (12) @(negedge sys_clk);
      chk("offhook", 5'b11011, {cl, aud, lps, lz, bst});
      chk("boost", 16'h1200, tgt);
      offHook = 1'b0;
      repeat (40) @(negedge sys_clk);
      chk("onhook", 5'b00100, {cl, aud, lps, lz, bst});
      chk("target", 16'h1000, tgt);
      bat = 16'h1100;
      repeat (12) @(negedge sys_clk);
      chk("track", 16'h0F00, trk);
   endtask
   // Ring trip while ringing, ring ground in tip open
   task automatic t_ground();
      wr(8'h04);
      offHook = 1'b1;
      repeat (12) @(negedge sys_clk);
      chk("trip", 2'b10, {trp, gnd});
      offHook = 1'b0;
      wr(8'h03);
      gndLead = 1'b1;
      repeat (12) @(negedge sys_clk);
      chk("ground", 2'b01, {trp, gnd});
      gndLead = 1'b0;
   endtask
   // Fault forces open and refuses writes
   task automatic t_fault();
      pf = 1'b1;
      repeat (6) @(negedge sys_clk);
      wr(8'h01);
      chk("fault", 4'b1000, {seenEv, rd[2:0]});
      pf = 1'b0;
      limSet = 5'h1F;
      @(negedge sys_clk);
      @(negedge sys_clk);
      chk("limit", 5'h1E, lim);
   endtask
   initial begin
      repeat (12) @(negedge sys_clk);
      sys_rst = 1'b0;
      t_states();
      t_hook();
      t_ground();
      t_fault();
      close_out();
   end
endmodule // linefeed_ctrl_bench
